/* File: src/lwu_params.svh */
// offsets, field positions, reset values for the wakeup enable registers
`ifndef LWU_PARAMS_SVH
`define LWU_PARAMS_SVH
`define LWU_IDX_PIN_CFG_HI 3
`define LWU_IDX_MOD_EN 4
`define LWU_IDX_MOD_FLAG 5
`define LWU_IDX_IRQ_STAT 6
`define LWU_IDX_IRQ_MASK 7
`define LWU_ADDR_W 5
`define LWU_PIN_CFG_HI_RST 8'h00
`define LWU_MOD_EN_RST 8'h00
`define LWU_FIELD_W 2
`define LWU_PIN_BASE 12
`define LWU_IRQ_FLAG_SET 0
`define LWU_IRQ_CFG_WR 1
`endif

/* File: src/lwu_pkg.sv */
// types shared by the wakeup enable register bank
package lwu_pkg;
  typedef enum logic [1:0] {
    LWU_MODE_OFF = 2'h0,
    LWU_MODE_RISE = 2'h1,
    LWU_MODE_FALL = 2'h2,
    LWU_MODE_ANY = 2'h3
  } lwu_mode_e;
  typedef enum logic [1:0] {
    LWU_BUS_IDLE = 2'h1,
    LWU_BUS_ACK = 2'h2
  } lwu_bus_e;
endpackage

/* File: src/lwu_regs.sv */
// wakeup pin mode and module enable registers with avalon-mm slave
`include "lwu_params.svh"

// Notes on behaviour
// - each 2-bit pin field: 00 off, 01 rising, 10 falling, 11 any change
// - pin config register: pin15 bits 7-6 down to pin12 bits 1-0
// - pin config register at offset 3, pins 12 to 15 only
// - module enable bit 1 makes module flag a wakeup source, 0 excludes it
// - module enable register at offset 4, bits 7..0 for module inputs 7..0
// - registers reset only by chip reset excluding deepest low-leak recovery
// - all module enable bits reset to zero
// - wakeup flag clears only by writing one, stays set if enable dropped
module lwu_regs #(
  parameter int NUM_PINS = 4,
  parameter int NUM_MODS = 8
) (
  // clock and reset (chip reset excluding deepest mode recovery)
  input wire logic clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [`LWU_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  // module wake flag inputs from peripherals, same clock
  input wire logic [NUM_MODS-1:0] module_wake_inputs_i,
  // to edge detection and flag logic
  output logic [NUM_PINS-1:0] pin_rise_en_o,
  output logic [NUM_PINS-1:0] pin_fall_en_o,
  output logic [2*NUM_PINS-1:0] pin_detect_mode_o,
  output logic [NUM_MODS-1:0] module_wake_en_o,
  output logic module_wake_o,
  // interrupt
  output logic irq_o
);

  logic [7:0] pin_cfg_q, pin_cfg_d;
  logic [7:0] mod_en_q, mod_en_d;
  logic [7:0] mod_flag_q, mod_flag_d;
  logic [1:0] irq_stat_q, irq_stat_d;
  logic [1:0] irq_mask_q, irq_mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] resp_q, resp_d;
  lwu_pkg::lwu_bus_e bus_q, bus_d;
  logic acc_rd, acc_wr, wr_lane0, hit;
  logic [7:0] wdat;
  logic [NUM_PINS-1:0] rise_q, fall_q;
  wire logic [NUM_PINS-1:0] rise_d, fall_d;
  logic wake_q, wake_d, irq_q, irq_d;

  // word index from byte address
  function automatic logic [2:0] word_idx(input logic [`LWU_ADDR_W-1:0] a);
    word_idx = a[`LWU_ADDR_W-1:2];
  endfunction

  function automatic logic is_reg(input logic [`LWU_ADDR_W-1:0] a, input int idx);
    is_reg = (word_idx(a) == 3'(idx));
  endfunction

  // field decode shared by every pin
  function automatic logic mode_rise(input logic [1:0] f);
    mode_rise = (f == lwu_pkg::LWU_MODE_RISE) || (f == lwu_pkg::LWU_MODE_ANY);
  endfunction

  function automatic logic mode_fall(input logic [1:0] f);
    mode_fall = (f == lwu_pkg::LWU_MODE_FALL) || (f == lwu_pkg::LWU_MODE_ANY);
  endfunction

  // requests are taken from idle only; read data and response latch here
  assign acc_rd = avs_read_i && (bus_q == lwu_pkg::LWU_BUS_IDLE);
  assign acc_wr = avs_write_i && (bus_q == lwu_pkg::LWU_BUS_IDLE);
  // a write lands only at the edge where the master sees waitrequest low
  assign wr_lane0 = avs_write_i && (bus_q == lwu_pkg::LWU_BUS_ACK) && avs_byteenable_i[0];
  assign wdat = avs_writedata_i[7:0];
  assign hit = is_reg(avs_address_i, `LWU_IDX_PIN_CFG_HI)
    || is_reg(avs_address_i, `LWU_IDX_MOD_EN)
    || is_reg(avs_address_i, `LWU_IDX_MOD_FLAG)
    || is_reg(avs_address_i, `LWU_IDX_IRQ_STAT)
    || is_reg(avs_address_i, `LWU_IDX_IRQ_MASK);

  // bus handshake: one wait cycle, answered the next
  always_comb
  begin
    bus_d = bus_q;
    case (bus_q)
      lwu_pkg::LWU_BUS_IDLE:
      begin
        if (avs_read_i || avs_write_i)
        begin
          bus_d = lwu_pkg::LWU_BUS_ACK;
        end
      end
      lwu_pkg::LWU_BUS_ACK:
      begin
        bus_d = lwu_pkg::LWU_BUS_IDLE;
      end
      default:
      begin
        bus_d = lwu_pkg::LWU_BUS_IDLE;
      end
    endcase
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (bus_q != lwu_pkg::LWU_BUS_ACK);

  // register writes
  always_comb
  begin
    pin_cfg_d = pin_cfg_q;
    mod_en_d = mod_en_q;
    irq_mask_d = irq_mask_q;
    if (wr_lane0 && is_reg(avs_address_i, `LWU_IDX_PIN_CFG_HI))
    begin
      pin_cfg_d = wdat;
    end
    if (wr_lane0 && is_reg(avs_address_i, `LWU_IDX_MOD_EN))
    begin
      mod_en_d = wdat;
    end
    if (wr_lane0 && is_reg(avs_address_i, `LWU_IDX_IRQ_MASK))
    begin
      irq_mask_d = wdat[1:0];
    end
  end

  // module wake flags: set by enabled source, w1c, set beats clear
  always_comb
  begin
    mod_flag_d = mod_flag_q;
    if (wr_lane0 && is_reg(avs_address_i, `LWU_IDX_MOD_FLAG))
    begin
      mod_flag_d = mod_flag_q & ~wdat;
    end
    mod_flag_d = mod_flag_d | (module_wake_inputs_i & mod_en_q);
  end

  // interrupt status: flag set event and config write event
  always_comb
  begin
    irq_stat_d = irq_stat_q;
    if (wr_lane0 && is_reg(avs_address_i, `LWU_IDX_IRQ_STAT))
    begin
      irq_stat_d = irq_stat_q & ~wdat[1:0];
    end
    if (|(module_wake_inputs_i & mod_en_q & ~mod_flag_q))
    begin
      irq_stat_d[`LWU_IRQ_FLAG_SET] = 1'b1;
    end
    if (wr_lane0 && (is_reg(avs_address_i, `LWU_IDX_PIN_CFG_HI)
        || is_reg(avs_address_i, `LWU_IDX_MOD_EN)))
    begin
      irq_stat_d[`LWU_IRQ_CFG_WR] = 1'b1;
    end
  end

  // read data and response, latched on request acceptance
  always_comb
  begin
    rdata_d = rdata_q;
    resp_d = resp_q;
    if (acc_rd || acc_wr)
    begin
      resp_d = hit ? 2'h0 : 2'h3;
      rdata_d = 32'h0;
      if (acc_rd)
      begin
        case (word_idx(avs_address_i))
          3'(`LWU_IDX_PIN_CFG_HI): rdata_d = {24'h0, pin_cfg_q};
          3'(`LWU_IDX_MOD_EN): rdata_d = {24'h0, mod_en_q};
          3'(`LWU_IDX_MOD_FLAG): rdata_d = {24'h0, mod_flag_q};
          3'(`LWU_IDX_IRQ_STAT): rdata_d = {30'h0, irq_stat_q};
          3'(`LWU_IDX_IRQ_MASK): rdata_d = {30'h0, irq_mask_q};
          default: rdata_d = 32'h0;
        endcase
      end
    end
  end

  // outputs follow the next register values, so they move on the same edge
  // as the registers behind them and never glitch between edges
  always_comb
  begin
    wake_d = |mod_flag_d;
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  // per pin decode of the next detect mode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_pin
      logic [1:0] fld;
      assign fld = pin_cfg_d[`LWU_FIELD_W*gi +: `LWU_FIELD_W];
      assign rise_d[gi] = mode_rise(fld);
      assign fall_d[gi] = mode_fall(fld);
    end
  endgenerate

  // only the chip reset reaches this block; other resets leave it alone
  // bus handshake state
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      bus_q <= lwu_pkg::LWU_BUS_IDLE;
    end
    else
    begin
      bus_q <= bus_d;
    end
  end

  // software configuration
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_cfg_q <= `LWU_PIN_CFG_HI_RST;
      mod_en_q <= `LWU_MOD_EN_RST;
      irq_mask_q <= 2'h0;
    end
    else
    begin
      pin_cfg_q <= pin_cfg_d;
      mod_en_q <= mod_en_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // module wake flags
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mod_flag_q <= 8'h00;
    end
    else
    begin
      mod_flag_q <= mod_flag_d;
    end
  end

  // interrupt status
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat_q <= 2'h0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // read data and response
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q <= 32'h0;
      resp_q <= 2'h0;
    end
    else
    begin
      rdata_q <= rdata_d;
      resp_q <= resp_d;
    end
  end

  // registered decode, wake and interrupt outputs
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rise_q <= '0;
      fall_q <= '0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      rise_q <= rise_d;
      fall_q <= fall_d;
      wake_q <= wake_d;
      irq_q <= irq_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_response_o = resp_q;
  assign pin_detect_mode_o = pin_cfg_q;
  assign pin_rise_en_o = rise_q;
  assign pin_fall_en_o = fall_q;
  assign module_wake_en_o = mod_en_q;
  assign module_wake_o = wake_q;
  assign irq_o = irq_q;

endmodule

/* File: verif/lwu_mod_src.sv */
// peripheral flag sources for the wakeup unit
module lwu_mod_src (
  input wire logic clk_i,
  input wire logic [7:0] raise_i,
  output logic [7:0] flags_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i) flags_o <= raise_i;
endmodule

/* File: verif/lwu_regs_sva.sv */
// checker for the wakeup register bank ports
module lwu_regs_sva #(parameter int NUM_PINS = 4, parameter int NUM_MODS = 8) (
  input wire logic clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, module_wake_o,
  input wire logic [4:0] avs_address_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [NUM_MODS-1:0] module_wake_inputs_i, module_wake_en_o,
  input wire logic [NUM_PINS-1:0] pin_rise_en_o, pin_fall_en_o,
  input wire logic [2*NUM_PINS-1:0] pin_detect_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic go, wo;
  logic [7:0] m;
  assign go = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  assign wo = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign m = pin_detect_mode_o;
  AST_MODE: assert property
    (wo && avs_address_i[4:2] == 3'h3 |=> m == $past(avs_writedata_i[7:0])) else $error("mode");
  AST_EN: assert property
    (wo && avs_address_i[4:2] == 3'h4 |=> module_wake_en_o == $past(avs_writedata_i[7:0]))
    else $error("enable");
  AST_DECODE: assert property
    ({pin_rise_en_o, pin_fall_en_o} == {m[6], m[4], m[2], m[0], m[7], m[5], m[3], m[1]})
    else $error("decode");
  AST_HOLD: assert property
    (!wo |=> $stable({m, module_wake_en_o})) else $error("hold");
  AST_RESET: assert property
    (disable iff (1'b0) !rst_n_i |=> {m, module_wake_en_o} == 16'h0000) else $error("reset");
  AST_WAIT: assert property
    (go |=> !avs_waitrequest_o) else $error("wait");
  AST_SRC: assert property
    ((module_wake_inputs_i & module_wake_en_o) != 8'h00 |=> module_wake_o) else $error("src");
  AST_STICKY: assert property
    (module_wake_o && !(wo && avs_address_i[4:2] == 3'h5) |=> module_wake_o) else $error("flag");
  cover property (wo ##3 wo);
  cover property (module_wake_o ##1 !module_wake_o);
  cover property (go && avs_read_i);
endmodule

bind lwu_regs lwu_regs_sva #(.NUM_PINS(NUM_PINS), .NUM_MODS(NUM_MODS)) lwu_regs_sva_i (.*);

/* File: verif/lwu_regs_tb.sv */
// bench for the wakeup register bank
module lwu_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wq, mw, irq;
  logic [4:0] ad = 5'h00;
  logic [3:0] be = 4'hF, ri, fa;
  logic [31:0] wd = 32'h0, q, rq;
  logic [1:0] rsp;
  logic [7:0] up = 8'h00, fl, m, md, en;
  int n_fail = 0, cmp_count = 0, seed = 15, cyc = 0;
  always #12.5 clk = ~clk;
  lwu_mod_src lwu_mod_src_i (.clk_i(clk), .raise_i(up), .flags_o(fl));
  lwu_regs lwu_regs_i (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(ad), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rq),
    .avs_waitrequest_o(wq), .avs_response_o(rsp), .module_wake_inputs_i(fl),
    .pin_rise_en_o(ri), .pin_fall_en_o(fa), .pin_detect_mode_o(md),
    .module_wake_en_o(en), .module_wake_o(mw), .irq_o(irq));
  function automatic logic [3:0] ev(input logic [7:0] v);
    return {v[6], v[4], v[2], v[0]};
  endfunction
  task chk(input logic [47:0] g, input logic [47:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= {24'h0, d};
    do @(posedge clk); while (wq !== 1'b0);
    q = rq;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rst;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task end_sim(input int t);
    n_fail += t;
    $display("%0d fails, %0d checks", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 2000) end_sim(1);
  initial
  begin
    rst;
    bus(0, 5'h0C, 8'h00);
    chk(q, 0);
    bus(0, 5'h10, 8'h00);
    chk(q, 0);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      m = i == 0 ? 8'h1B : 8'($random(seed));
      bus(1, 5'h0C, m);
      bus(0, 5'h0C, 8'h00);
      chk({ri, fa, md}, {ev(m), ev(m >> 1), m});
      chk(q, m);
      bus(1, 5'h10, ~m);
      bus(0, 5'h10, 8'h00);
      chk({q[7:0], en}, {~m, ~m});
    end
    be <= 4'hE;
    bus(1, 5'h0C, ~m);
    be <= 4'hF;
    bus(1, 5'h00, 8'hFF);
    bus(0, 5'h00, 8'h00);
    chk({rsp, q, md}, {2'h3, 32'h0, m});
    $display("config test done");
    bus(1, 5'h10, 8'h05);
    bus(1, 5'h1C, 8'h01);
    chk(irq, 0);
    up <= 8'h04;
    repeat (4) @(negedge clk);
    chk({mw, irq}, 2'h3);
    up <= 8'h00;
    bus(1, 5'h10, 8'h00);
    chk(mw, 1);
    bus(0, 5'h14, 8'h00);
    chk(q, 32'h4);
    bus(0, 5'h18, 8'h00);
    chk(q, 32'h3);
    up <= 8'h02;
    bus(1, 5'h14, 8'hFF);
    bus(1, 5'h18, 8'hFF);
    @(negedge clk);
    chk({mw, irq}, 2'h0);
    up <= 8'h00;
    $display("flag test done");
    bus(1, 5'h10, 8'hA5);
    rst;
    @(posedge clk);
    chk({md, en}, 16'h0);
    bus(0, 5'h10, 8'h00);
    chk(q, 0);
    $display("rerun test done");
    end_sim(0);
  end
endmodule
